// ===== src/mac_fifo_datapath.sv
// Frame datapath: host byte streams, two frame FIFOs, nibble MAC and MDIO.
// Assumes PHY pins are asynchronous to ref_clk and link clocks are slow.
// How it works
// - Separate 3 Kbyte transmit and receive FIFOs.
// - Queued frames go out after minimum gap.
// - Transmission starts once threshold data is buffered.
// - Failed frames are resent from FIFO data.
// - Short received frames are dropped before host.
// - Host bursts run against FIFOs, not link.
// - Deep FIFOs ride out long host latency.
// - Transmit bytes leave as nibbles.
// - Received nibbles are assembled into bytes.
// - One nibble interface for any PHY.
// - Timing follows link clock, either speed.
// - Preamble, deferral, jam and backoff handled.
// - Full duplex ignores carrier and collision.
// - Management port reads and writes PHY registers.
`timescale 1ns/1ps
module mac_fifo_datapath
  import mac_fifo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire fifo_word_t tx_in,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output fifo_word_t rx_out,
  input wire logic [ADDR_W:0] tx_threshold,
  input wire logic full_duplex,
  input wire logic runt_discard,
  input wire logic tx_clk,
  output logic [3:0] txd,
  output logic tx_en,
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic col,
  input wire logic mgmt_start,
  input wire mgmt_req_t mgmt_req,
  output logic mgmt_busy,
  output logic [15:0] mgmt_rdata,
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  output logic tx_done,
  output logic tx_underrun,
  output logic tx_abort,
  output logic rx_frame,
  output logic rx_runt,
  output logic rx_overrun
);

  pin_sync_t s1_reg, s2_reg;
  logic s3_tx_clk_reg, s3_rx_clk_reg;
  wire pin_sync_t pins = '{mdio: mdio_i, rxd: rxd, rx_dv: rx_dv, col: col, crs: crs,
                           rx_clk: rx_clk, tx_clk: tx_clk};

  // Both PHY kinds present the same pins, so one sampler serves either.
  // Link clock edges are found by sampling, so ref_clk must run well above the
  // nibble clock; the 25 MHz rate needs a faster ref_clk than the bench uses.
  wire tx_rise = s2_reg.tx_clk && !s3_tx_clk_reg;
  wire rx_rise = s2_reg.rx_clk && !s3_rx_clk_reg;
  wire half = !full_duplex;
  wire col_hit = half && s2_reg.col;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_tx_clk_reg <= 1'b0;
      s3_rx_clk_reg <= 1'b0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_tx_clk_reg <= s2_reg.tx_clk;
      s3_rx_clk_reg <= s2_reg.rx_clk;
    end
  end

  // Transmit FIFO and state.
  fifo_word_t tx_f;
  logic tx_f_valid, tx_take, tx_rewind, tx_commit, tx_retry;
  logic [ADDR_W:0] tx_level;
  tx_state_t tx_state_reg, tx_state_next;
  logic [7:0] tx_cnt_reg, tx_cnt_next, tx_byte_reg, tx_byte_next;
  logic tx_hi_reg, tx_hi_next, tx_last_reg, tx_last_next, tx_en_reg, tx_en_next;
  logic [3:0] txd_reg, txd_next;
  logic [4:0] tx_att_reg, tx_att_next;
  logic [16:0] tx_bo_reg, tx_bo_next;
  logic [9:0] lfsr_reg;
  logic [ADDR_W:0] frames_q_reg;
  logic tx_done_next, tx_underrun_next, tx_abort_next;

  function automatic logic [16:0] backoff_len(input logic [9:0] rnd, input logic [4:0] att);
    logic [4:0] k;
    logic [9:0] mask;
    k = (att > BACKOFF_EXP) ? BACKOFF_EXP : att;
    mask = 10'((11'h001 << k) - 11'h001);
    return 17'(rnd & mask) * SLOT_NIBBLES;
  endfunction

  // Frames are held until sent, so retries and host bursts never touch the
  // link rate.
  frame_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(ADDR_W)) tx_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in),
    .wr_commit(1'b1),
    .wr_rewind(1'b0),
    .out_valid(tx_f_valid),
    .out_ready(tx_take),
    .out_data(tx_f),
    .rd_commit(tx_commit),
    .rd_rewind(tx_rewind),
    .level(tx_level)
  );

  wire push_last = tx_in_valid && tx_in_ready && tx_in.last;
  // A complete queued frame may start even below the threshold.
  wire tx_go = tx_f_valid && (tx_level >= tx_threshold || frames_q_reg != '0);
  wire tx_final = tx_att_reg == MAX_ATTEMPTS - 5'h01;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_byte_next = tx_byte_reg;
    tx_hi_next = tx_hi_reg;
    tx_last_next = tx_last_reg;
    tx_en_next = tx_en_reg;
    txd_next = txd_reg;
    tx_att_next = tx_att_reg;
    tx_bo_next = tx_bo_reg;
    tx_take = 1'b0;
    tx_commit = 1'b0;
    tx_retry = 1'b0;
    tx_done_next = 1'b0;
    tx_underrun_next = 1'b0;
    case (tx_state_reg)
      TX_DEFER: begin
        // Gap is counted in nibble clocks, so it scales with link speed.
        if (half && s2_reg.crs) begin
          tx_cnt_next = IFG_NIBBLES;
        end else if (tx_rise) begin
          if (tx_cnt_reg != 8'h00) begin
            tx_cnt_next = tx_cnt_reg - 8'h01;
          end else if (tx_go) begin
            tx_state_next = TX_PRE;
            tx_en_next = 1'b1;
            txd_next = NIB_PRE;
            tx_cnt_next = PREAMBLE_NIBBLES - 8'h01;
          end
        end
      end
      TX_PRE, TX_DATA: begin
        if (col_hit) begin
          tx_state_next = TX_JAM;
          tx_cnt_next = JAM_NIBBLES;
        end else if (tx_rise && tx_state_reg == TX_PRE) begin
          txd_next = (tx_cnt_reg != 8'h00) ? NIB_PRE : NIB_SFD;
          tx_cnt_next = tx_cnt_reg - 8'h01;
          if (tx_cnt_reg == 8'h00) begin
            tx_state_next = TX_DATA;
            tx_hi_next = 1'b0;
            tx_last_next = 1'b0;
          end
        end else if (tx_rise) begin
          if (tx_hi_reg) begin
            txd_next = tx_byte_reg[7:4];
            tx_hi_next = 1'b0;
          end else if (tx_last_reg) begin
            tx_en_next = 1'b0;
            tx_commit = 1'b1;
            tx_done_next = 1'b1;
            tx_att_next = '0;
            tx_cnt_next = IFG_NIBBLES;
            tx_state_next = TX_DEFER;
          end else if (tx_f_valid) begin
            txd_next = tx_f.data[3:0];
            tx_byte_next = tx_f.data;
            tx_last_next = tx_f.last;
            tx_hi_next = 1'b1;
            tx_take = 1'b1;
          end else begin
            tx_en_next = 1'b0;
            tx_underrun_next = 1'b1;
            tx_retry = 1'b1;
          end
        end
      end
      TX_JAM: begin
        if (tx_rise) begin
          if (tx_cnt_reg != 8'h00) begin
            txd_next = NIB_JAM;
            tx_cnt_next = tx_cnt_reg - 8'h01;
          end else begin
            tx_en_next = 1'b0;
            tx_retry = 1'b1;
          end
        end
      end
      TX_BACKOFF: begin
        if (tx_rise) begin
          if (tx_bo_reg != '0) begin
            tx_bo_next = tx_bo_reg - 17'h00001;
          end else begin
            tx_state_next = TX_DEFER;
            tx_cnt_next = IFG_NIBBLES;
          end
        end
      end
      TX_DRAIN: begin
        tx_take = tx_f_valid;
        if (tx_f_valid && tx_f.last) begin
          tx_commit = 1'b1;
          tx_state_next = TX_DEFER;
          tx_cnt_next = IFG_NIBBLES;
        end
      end
      default: begin
        tx_state_next = TX_DEFER;
      end
    endcase
    // A failed attempt rewinds to the frame start; after too many it is dropped.
    if (tx_retry) begin
      tx_att_next = tx_final ? 5'h00 : tx_att_reg + 5'h01;
      tx_state_next = tx_final ? TX_DRAIN : TX_BACKOFF;
      tx_bo_next = backoff_len(lfsr_reg, tx_att_reg + 5'h01);
    end
  end

  assign tx_rewind = tx_retry;
  assign tx_abort_next = tx_retry && tx_final;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_state_reg <= TX_DEFER;
      tx_cnt_reg <= IFG_NIBBLES;
      tx_byte_reg <= '0;
      tx_hi_reg <= 1'b0;
      tx_last_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      txd_reg <= '0;
      tx_att_reg <= '0;
      tx_bo_reg <= '0;
      lfsr_reg <= LFSR_SEED;
      frames_q_reg <= '0;
      tx_done <= 1'b0;
      tx_underrun <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_byte_reg <= tx_byte_next;
      tx_hi_reg <= tx_hi_next;
      tx_last_reg <= tx_last_next;
      tx_en_reg <= tx_en_next;
      txd_reg <= txd_next;
      tx_att_reg <= tx_att_next;
      tx_bo_reg <= tx_bo_next;
      lfsr_reg <= {lfsr_reg[8:0], lfsr_reg[9] ^ lfsr_reg[6]};
      frames_q_reg <= frames_q_reg + (ADDR_W+1)'(push_last) - (ADDR_W+1)'(tx_commit);
      tx_done <= tx_done_next;
      tx_underrun <= tx_underrun_next;
      tx_abort <= tx_abort_next;
    end
  end

  assign txd = txd_reg;
  assign tx_en = tx_en_reg;

  // Receive path.
  rx_state_t rx_state_reg, rx_state_next;
  logic [3:0] rx_lo_reg, rx_lo_next;
  logic [7:0] rx_pend_reg, rx_pend_next;
  logic rx_hi_reg, rx_hi_next, rx_have_reg, rx_have_next;
  logic [6:0] rx_cnt_reg, rx_cnt_next;
  logic rx_wr_valid, rx_in_ready, rx_commit, rx_rewind;
  logic rx_frame_next, rx_runt_next, rx_overrun_next;
  fifo_word_t rx_wr;

  frame_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(ADDR_W)) rx_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(rx_wr_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_wr),
    .wr_commit(rx_commit),
    .wr_rewind(rx_rewind),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out),
    .rd_commit(1'b1),
    .rd_rewind(1'b0),
    .level()
  );

  // Each byte is held back one byte so that the last one can carry the end mark.
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_lo_next = rx_lo_reg;
    rx_pend_next = rx_pend_reg;
    rx_hi_next = rx_hi_reg;
    rx_have_next = rx_have_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_wr_valid = 1'b0;
    rx_wr = '{last: 1'b0, data: rx_pend_reg};
    rx_commit = 1'b0;
    rx_rewind = 1'b0;
    rx_frame_next = 1'b0;
    rx_runt_next = 1'b0;
    rx_overrun_next = 1'b0;
    case (rx_state_reg)
      RX_IDLE: begin
        if (rx_rise && s2_reg.rx_dv) begin
          rx_state_next = RX_PRE;
        end
      end
      RX_PRE: begin
        if (rx_rise) begin
          if (!s2_reg.rx_dv) begin
            rx_state_next = RX_IDLE;
          end else if (s2_reg.rxd == NIB_SFD) begin
            rx_state_next = RX_DATA;
            rx_hi_next = 1'b0;
            rx_have_next = 1'b0;
            rx_cnt_next = '0;
          end
        end
      end
      RX_DATA: begin
        if (rx_rise && !s2_reg.rx_dv) begin
          rx_state_next = RX_IDLE;
          if (runt_discard && rx_cnt_reg < MIN_FRAME) begin
            rx_rewind = 1'b1;
            rx_runt_next = 1'b1;
          end else if (rx_have_reg && !rx_in_ready) begin
            rx_rewind = 1'b1;
            rx_overrun_next = 1'b1;
          end else begin
            rx_wr_valid = rx_have_reg;
            rx_wr.last = 1'b1;
            rx_commit = 1'b1;
            rx_frame_next = 1'b1;
          end
        end else if (rx_rise && !rx_hi_reg) begin
          rx_lo_next = s2_reg.rxd;
          rx_hi_next = 1'b1;
        end else if (rx_rise) begin
          rx_hi_next = 1'b0;
          rx_pend_next = {s2_reg.rxd, rx_lo_reg};
          rx_have_next = 1'b1;
          rx_cnt_next = (rx_cnt_reg < MIN_FRAME) ? rx_cnt_reg + 7'h01 : rx_cnt_reg;
          rx_wr_valid = rx_have_reg;
          if (rx_have_reg && !rx_in_ready) begin
            rx_rewind = 1'b1;
            rx_overrun_next = 1'b1;
            rx_state_next = RX_DROP;
          end
        end
      end
      RX_DROP: begin
        if (rx_rise && !s2_reg.rx_dv) begin
          rx_state_next = RX_IDLE;
        end
      end
      default: begin
        rx_state_next = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_state_reg <= RX_IDLE;
      rx_lo_reg <= '0;
      rx_pend_reg <= '0;
      rx_hi_reg <= 1'b0;
      rx_have_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_frame <= 1'b0;
      rx_runt <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_lo_reg <= rx_lo_next;
      rx_pend_reg <= rx_pend_next;
      rx_hi_reg <= rx_hi_next;
      rx_have_reg <= rx_have_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_frame <= rx_frame_next;
      rx_runt <= rx_runt_next;
      rx_overrun <= rx_overrun_next;
    end
  end

  // Management port: 64-bit frame, driven on MDC fall, sampled on MDC rise.
  logic mg_write_reg;
  logic [2:0] mg_div_reg;
  logic [63:0] mg_shift_reg;
  logic [6:0] mg_bit_reg;
  wire mg_tick = mg_div_reg == MDC_HALF_CYC - 3'h1;
  wire mg_go = mgmt_start && !mgmt_busy;
  wire [63:0] mg_frame = {MDIO_PRE, MDIO_ST, mgmt_req.write ? MDIO_OP_WR : MDIO_OP_RD,
                          mgmt_req.phy, mgmt_req.regn,
                          mgmt_req.write ? MDIO_TA_WR : 2'h0, mgmt_req.wdata};
  wire mg_rise = mgmt_busy && mg_tick && !mdc;
  wire mg_fall = mgmt_busy && mg_tick && mdc;
  wire mg_sample = mg_rise && !mg_write_reg && mg_bit_reg > MDIO_DATA_START;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mgmt_busy <= 1'b0;
      mg_write_reg <= 1'b0;
      mg_div_reg <= '0;
      mg_shift_reg <= '0;
      mg_bit_reg <= '0;
      mgmt_rdata <= '0;
      mdc <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (mg_go) begin
      mgmt_busy <= 1'b1;
      mg_write_reg <= mgmt_req.write;
      mg_div_reg <= '0;
      mdio_o <= mg_frame[63];
      mdio_oe <= 1'b1;
      mg_shift_reg <= {mg_frame[62:0], 1'b0};
      mg_bit_reg <= 7'h01;
    end else begin
      mg_div_reg <= (mgmt_busy && !mg_tick) ? mg_div_reg + 3'h1 : 3'h0;
      mdc <= mgmt_busy && mg_tick ? !mdc : mdc;
      if (mg_sample) begin
        mgmt_rdata <= {mgmt_rdata[14:0], s2_reg.mdio};
      end
      if (mg_fall && mg_bit_reg == MDIO_BITS) begin
        mgmt_busy <= 1'b0;
        mdio_oe <= 1'b0;
      end else if (mg_fall) begin
        mdio_o <= mg_shift_reg[63];
        mdio_oe <= mg_write_reg || mg_bit_reg < MDIO_DRIVE_RD;
        mg_shift_reg <= {mg_shift_reg[62:0], 1'b0};
        mg_bit_reg <= mg_bit_reg + 7'h01;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  logic [7:0] gap_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gap_reg <= 8'hff;
    end else if (tx_en_reg) begin
      gap_reg <= '0;
    end else if (tx_rise && gap_reg != 8'hff) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  sequence s_defer_go;
    tx_state_reg == TX_DEFER ##1 tx_state_reg == TX_PRE;
  endsequence

  sequence s_low_first;
    tx_take && tx_state_reg == TX_DATA;
  endsequence

  a_tx_gap: assert property ($rose(tx_en_reg) |-> gap_reg >= IFG_NIBBLES)
    else $error("Frame started before the interframe gap ended.");
  a_tx_start: assert property (s_defer_go |-> $past(tx_go) && tx_en_reg)
    else $error("Frame started without enough buffered data.");
  a_low_nibble: assert property (s_low_first |=> txd_reg == $past(tx_f.data[3:0]))
    else $error("Low nibble was not sent first.");
  a_underrun_end: assert property (tx_underrun_next |=> !tx_en_reg && tx_underrun)
    else $error("Underrun did not end the frame.");
  a_retry_fifo: assert property ($rose(tx_underrun) |-> $past(tx_rewind))
    else $error("Retry did not rewind the transmit FIFO.");
  a_runt_drop: assert property (rx_runt |-> $past(rx_rewind) && !$past(rx_commit))
    else $error("Runt frame was kept.");
  a_fdx_no_jam: assert property (full_duplex && tx_state_reg != TX_JAM |=>
    tx_state_reg != TX_JAM)
    else $error("Full duplex reacted to a collision.");
  a_mdio_turn: assert property (mgmt_busy && !mg_write_reg &&
    mg_bit_reg > MDIO_DRIVE_RD |-> !mdio_oe)
    else $error("Read frame still drives the data line.");
  a_mdc_high: assert property ($rose(mdc) |-> mdc [*4])
    else $error("Management clock high phase has the wrong length.");

endmodule

// ===== src/mac_fifo_pkg.sv
// Shared constants, carrier types and state encodings for the frame datapath.
// Assumes a 20 MHz ref_clk and a nibble-wide PHY link sampled by that clock.
package mac_fifo_pkg;

  localparam int REF_NS = 50;
  localparam int FIFO_DEPTH = 3072;
  localparam int ADDR_W = 12;

  localparam int IFG_NS = 960;
  localparam int NIBBLE_NS_100 = 40;
  localparam logic [7:0] IFG_NIBBLES = 8'(IFG_NS / NIBBLE_NS_100);
  localparam logic [7:0] PREAMBLE_NIBBLES = 8'h0f;
  localparam logic [7:0] JAM_NIBBLES = 8'h08;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_SFD = 4'hd;
  localparam logic [3:0] NIB_JAM = 4'h5;
  localparam logic [6:0] MIN_FRAME = 7'h40;
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] BACKOFF_EXP = 5'h0a;
  localparam logic [16:0] SLOT_NIBBLES = 17'h00080;
  localparam logic [9:0] LFSR_SEED = 10'h1ff;

  localparam int MDC_PERIOD_NS = 400;
  localparam logic [2:0] MDC_HALF_CYC = 3'((MDC_PERIOD_NS / 2 + REF_NS - 1) / REF_NS);
  localparam logic [6:0] MDIO_BITS = 7'h40;
  localparam logic [6:0] MDIO_DRIVE_RD = 7'h2e;
  localparam logic [6:0] MDIO_DATA_START = 7'h30;
  localparam logic [31:0] MDIO_PRE = 32'hffffffff;
  localparam logic [1:0] MDIO_ST = 2'h1;
  localparam logic [1:0] MDIO_OP_RD = 2'h2;
  localparam logic [1:0] MDIO_OP_WR = 2'h1;
  localparam logic [1:0] MDIO_TA_WR = 2'h2;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } fifo_word_t;

  localparam int FIFO_WIDTH = $bits(fifo_word_t);

  typedef struct packed {
    logic write;
    logic [4:0] phy;
    logic [4:0] regn;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic mdio;
    logic [3:0] rxd;
    logic rx_dv;
    logic col;
    logic crs;
    logic rx_clk;
    logic tx_clk;
  } pin_sync_t;

  typedef enum logic [2:0] {
    TX_DEFER = 3'h0,
    TX_PRE = 3'h1,
    TX_DATA = 3'h2,
    TX_JAM = 3'h3,
    TX_BACKOFF = 3'h4,
    TX_DRAIN = 3'h5
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_PRE = 2'h1,
    RX_DATA = 2'h2,
    RX_DROP = 2'h3
  } rx_state_t;

endpackage

// ===== src/frame_fifo.sv
// Byte FIFO with frame marks on both sides, registered read data.
// Assumes one clock; rewind restores the last committed pointer of that side.
`timescale 1ns/1ps
module frame_fifo
  import mac_fifo_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = ADDR_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic wr_commit,
  input wire logic wr_rewind,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  input wire logic rd_commit,
  input wire logic rd_rewind,
  output logic [AW:0] level
);

  logic [WIDTH-1:0] mem [0:(2**AW)-1];
  logic [AW:0] wptr_reg, wcom_reg, rptr_reg, rcom_reg, cons_reg;
  logic [AW:0] wptr_next, wcom_next, rptr_next, rcom_next, cons_next;
  logic vld_reg, rdy_reg;

  function automatic logic [AW:0] bump(input logic [AW:0] p, input logic en);
    return p + {{AW{1'b0}}, en};
  endfunction

  // Space is measured against the committed read side, so a frame under
  // transmission keeps its bytes until it is known to be done.
  wire push = in_valid && rdy_reg;
  wire pop = vld_reg && out_ready;
  wire load = (!vld_reg || out_ready) && (rptr_reg != wcom_reg) && !rd_rewind;
  wire [AW:0] used_next = wptr_next - rcom_next;
  wire [AW:0] depth_w = (AW+1)'(DEPTH);

  assign wptr_next = wr_rewind ? wcom_reg : bump(wptr_reg, push);
  assign wcom_next = wr_commit ? wptr_next : wcom_reg;
  assign cons_next = rd_rewind ? rcom_reg : bump(cons_reg, pop);
  assign rcom_next = rd_commit ? cons_next : rcom_reg;
  assign rptr_next = rd_rewind ? rcom_reg : bump(rptr_reg, load);
  assign in_ready = rdy_reg;
  assign out_valid = vld_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wptr_reg <= '0;
      wcom_reg <= '0;
      rptr_reg <= '0;
      rcom_reg <= '0;
      cons_reg <= '0;
      vld_reg <= 1'b0;
      rdy_reg <= 1'b0;
      level <= '0;
    end else begin
      wptr_reg <= wptr_next;
      wcom_reg <= wcom_next;
      rptr_reg <= rptr_next;
      rcom_reg <= rcom_next;
      cons_reg <= cons_next;
      vld_reg <= rd_rewind ? 1'b0 : load ? 1'b1 : pop ? 1'b0 : vld_reg;
      rdy_reg <= used_next < depth_w;
      level <= wcom_next - rcom_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_data <= '0;
    end else if (load) begin
      out_data <= mem[rptr_reg[AW-1:0]];
    end
  end

endmodule

// ===== verif/phy_model.sv
// PHY stand-in: free running nibble clocks, transmit capture and receive frames.
// Assumes a 400 ns link period and a pull-up on the management data line.
`timescale 1ns/1ps
module phy_model (
  output logic tx_clk,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic crs,
  output logic col,
  output logic mdio_i,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic mdc
);
  logic [3:0] txq[$];
  int gap;
  int min_gap = 1000;
  assign crs = rx_dv;
  assign col = 1'b0;
  logic [15:0] rd_word = 16'h5a3c;
  logic [63:0] wr_sh;
  logic rd_bit = 1'b1;
  int rd_n;
  // Read data is set up one MDC rise early; outside it the line is pulled high.
  assign mdio_i = mdio_oe ? mdio_o : rd_bit;
  always @(posedge mdc) begin
    wr_sh <= {wr_sh[62:0], mdio_o};
    if (mdio_oe) rd_n = 0;
    else begin
      rd_bit <= rd_n == 0 ? 1'b0 : rd_n < 17 ? rd_word[16 - rd_n] : 1'b1;
      rd_n++;
    end
  end
  initial begin
    tx_clk = 1'b0;
    forever #200 tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 1'b0;
    rx_dv = 1'b0;
    rxd = 4'h0;
    #130;
    forever #200 rx_clk = ~rx_clk;
  end
  // The nibble launched after one rise is stable at the next, so it is taken there.
  always @(posedge tx_clk) begin
    if (tx_en === 1'b1) begin
      txq.push_back(txd);
      if (gap > 0 && gap < min_gap) min_gap = gap;
      gap = 0;
    end else gap++;
  end
  task automatic send(input int n);
    logic [7:0] b;
    for (int i = 0; i < 16 + 2 * n; i++) begin
      b = 8'(8'h30 + (i - 16) / 2);
      @(negedge rx_clk);
      rx_dv <= 1'b1;
      rxd <= i < 15 ? 4'h5 : i == 15 ? 4'hd : i[0] ? b[7:4] : b[3:0];
    end
    @(negedge rx_clk);
    rx_dv <= 1'b0;
    rxd <= ~rxd;
  endtask
endmodule

// ===== verif/tb_top.sv
// Bench for the frame datapath: transmit, receive, short frames and management.
// Assumes the PHY stand-in phy_model and a 50 ns ref_clk.
`timescale 1ns/1ps
module tb_top;
  import mac_fifo_pkg::*;
  logic ref_clk, srst, tx_in_valid, rx_out_ready, full_duplex, runt_discard, mgmt_start;
  logic tx_in_ready, rx_out_valid, tx_clk, tx_en, rx_clk, rx_dv, crs, col, mgmt_busy;
  logic mdc, mdio_i, mdio_o, mdio_oe, tx_done, tx_underrun, tx_abort, rx_frame, rx_runt;
  logic rx_overrun;
  logic [3:0] txd, rxd;
  logic [15:0] mgmt_rdata;
  logic [ADDR_W:0] tx_threshold;
  fifo_word_t tx_in, rx_out, rxq[$];
  mgmt_req_t mgmt_req;
  int fail_count, n_compared, n_frame, n_runt, n_done, n_urun, n_bad;
  mac_fifo_datapath dut_u (.ref_clk, .srst, .tx_in_valid, .tx_in_ready, .tx_in, .rx_out_valid,
    .rx_out_ready, .rx_out, .tx_threshold, .full_duplex, .runt_discard, .tx_clk, .txd, .tx_en,
    .rx_clk, .rxd, .rx_dv, .crs, .col, .mgmt_start, .mgmt_req, .mgmt_busy, .mgmt_rdata, .mdc,
    .mdio_i, .mdio_o, .mdio_oe, .tx_done, .tx_underrun, .tx_abort, .rx_frame, .rx_runt,
    .rx_overrun);
  phy_model phy_u (.tx_clk, .rx_clk, .rxd, .rx_dv, .crs, .col, .mdio_i, .txd, .tx_en, .mdio_o,
    .mdio_oe, .mdc);
  always @(posedge ref_clk) begin
    if (rx_frame) n_frame++;
    if (rx_runt) n_runt++;
    if (tx_done) n_done++;
    if (tx_underrun) n_urun++;
    if (tx_abort || rx_overrun) n_bad++;
    if (rx_out_valid && rx_out_ready) rxq.push_back(rx_out);
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    tx_in_valid <= 1'b1;
    tx_in <= '{last: l, data: d};
    do @(negedge ref_clk); while (tx_in_ready !== 1'b1);
    @(posedge ref_clk);
  endtask
  task automatic t_tx;
    logic [7:0] b[6] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'hb0, 8'hb1};
    logic [3:0] e[$];
    for (int i = 0; i < 3; i++) push(b[i], 1'b0);
    tx_in_valid <= 1'b0;
    repeat (400) @(posedge ref_clk);
    chk(phy_u.txq.size() == 0, "frame started below threshold");
    for (int i = 3; i < 6; i++) push(b[i], i == 3 || i == 5);
    tx_in_valid <= 1'b0;
    for (int i = 0; i < 3000 && n_done < 2; i++) @(posedge ref_clk);
    for (int f = 0; f < 6; f += 4) begin
      repeat (15) e.push_back(NIB_PRE);
      e.push_back(NIB_SFD);
      for (int i = f; i < (f ? 6 : 4); i++) begin
        e.push_back(b[i][3:0]);
        e.push_back(b[i][7:4]);
      end
    end
    chk(phy_u.txq.size() == e.size(), "nibble count");
    foreach (e[i]) chk(phy_u.txq[i] === e[i], "nibble value");
    chk(phy_u.min_gap >= 23 && phy_u.min_gap <= 26, "gap between frames");
    chk(n_done == 2, "done pulses");
    $display("test transmit finished");
  endtask
  task automatic t_urun;
    phy_u.txq.delete();
    tx_threshold <= 13'h001;
    push(8'hc1, 1'b0);
    tx_in_valid <= 1'b0;
    for (int i = 0; i < 800 && n_urun == 0; i++) @(posedge ref_clk);
    chk(n_urun == 1 && phy_u.txq.size() == 18, "underrun frame");
    push(8'hc2, 1'b1);
    tx_in_valid <= 1'b0;
    for (int i = 0; i < 2500 && n_done < 3; i++) @(posedge ref_clk);
    chk(n_done == 3 && phy_u.txq.size() == 38 && phy_u.txq[34] === 4'h1, "resent");
    $display("test underrun finished");
  endtask
  task automatic t_rx;
    phy_u.send(64);
    for (int i = 0; i < 400 && rxq.size() < 64; i++) @(posedge ref_clk);
    chk(n_frame == 1 && rxq.size() == 64, "frame of 64 bytes");
    foreach (rxq[i]) chk(rxq[i] === {i == 63, 8'(8'h30 + i)}, "received byte");
    rxq.delete();
    phy_u.send(63);
    repeat (100) @(posedge ref_clk);
    chk(n_runt == 1 && n_frame == 1 && rxq.size() == 0, "short frame");
    runt_discard <= 1'b0;
    phy_u.send(63);
    for (int i = 0; i < 400 && rxq.size() < 63; i++) @(posedge ref_clk);
    chk(n_frame == 2 && rxq.size() == 63 && rxq[62].last, "short frame kept");
    $display("test receive finished");
  endtask
  task automatic t_mgmt(input logic w);
    int c = 0;
    mgmt_req <= mgmt_req_t'({w, 5'h01, 5'h02, 16'h1234});
    mgmt_start <= 1'b1;
    @(posedge ref_clk);
    mgmt_start <= 1'b0;
    @(negedge ref_clk);
    chk(mgmt_busy === 1'b1, "busy after start");
    while (mgmt_busy === 1'b1 && c < 700) begin
      @(negedge ref_clk);
      c++;
    end
    chk(c >= 500 && c <= 520, "management frame length");
    if (!w) chk(mgmt_rdata === phy_u.rd_word, "read data");
    else chk(phy_u.wr_sh === {MDIO_PRE, MDIO_ST, MDIO_OP_WR, 5'h01, 5'h02, MDIO_TA_WR,
      16'h1234}, "write frame");
    @(posedge ref_clk);
    $display("test management finished");
  endtask
  task automatic wrap_up;
    $display("Counts: compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // The whole run needs less than half of this span.
  initial begin
    #1_000_000;
    fail_count++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    tx_in_valid = 1'b0;
    tx_in = '0;
    rx_out_ready = 1'b1;
    full_duplex = 1'b1;
    runt_discard = 1'b1;
    mgmt_start = 1'b0;
    mgmt_req = '0;
    tx_threshold = 13'h004;
    repeat (19) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(tx_en === 1'b0 && txd === 4'h0 && mdc === 1'b0 && mdio_oe === 1'b0, "reset values");
    @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_tx();
    t_urun();
    t_rx();
    t_mgmt(1'b1);
    t_mgmt(1'b0);
    chk(n_bad == 0, "abort or overrun");
    wrap_up();
  end
endmodule
